/* core/pmic_irq_pkg.sv */
// Constants, types and register map for the event and interrupt block.
package pmic_irq_pkg;

   typedef logic [7:0]  byte_t;
   typedef logic [31:0] count_t;
   typedef logic [11:0] filt_count_t;

   // Clock and timing figures.
   localparam int     CLK_PERIOD_NS    = 4;
   localparam int     NS_PER_SECOND    = 1000000000;
   localparam count_t TICKS_PER_SECOND = count_t'(NS_PER_SECOND
                                                  / CLK_PERIOD_NS);
   localparam count_t KEY_LONG_PRESS_S = 32'h0000_0001;
   localparam int     DEBOUNCE_NS      = 16000;
   localparam int     DEBOUNCE_CYCLES  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
   localparam filt_count_t DEBOUNCE_LAST = filt_count_t'(DEBOUNCE_CYCLES - 1);

   // Register offsets.
   localparam byte_t ADDR_REVISION   = 8'h00;
   localparam byte_t ADDR_FLAGS_A    = 8'h01;
   localparam byte_t ADDR_FLAGS_B    = 8'h02;
   localparam byte_t ADDR_FLAGS_CLK  = 8'h03;
   localparam byte_t ADDR_MASK_A     = 8'h04;
   localparam byte_t ADDR_MASK_B     = 8'h05;
   localparam byte_t ADDR_MASK_CLK   = 8'h06;
   localparam byte_t ADDR_STATUS_A   = 8'h07;
   localparam byte_t ADDR_MR_CTRL    = 8'h0B;
   localparam byte_t ADDR_CAUSE      = 8'hE0;

   // Reset values.
   localparam byte_t MASK_A_RESET    = 8'h00;
   localparam byte_t MASK_B_RESET    = 8'h78;
   localparam byte_t MASK_CLK_RESET  = 8'h00;
   localparam byte_t MR_CTRL_RESET   = 8'h0E;
   localparam byte_t ZERO_BYTE       = 8'h00;

   // Flag bit positions.
   localparam int FA_FIX_RISE  = 5;
   localparam int FA_FIX_FALL  = 4;
   localparam int FA_KEY_LONG  = 3;
   localparam int FA_KEY_FALL  = 1;
   localparam int FA_KEY_RISE  = 0;
   localparam int FB_MANUAL    = 2;
   localparam int FB_AD_FALL   = 1;
   localparam int FB_AD_RISE   = 0;
   localparam int FC_WARM      = 5;
   localparam int FC_SECOND    = 4;
   localparam int FC_LOSS      = 3;
   localparam int FC_ALARM2    = 2;
   localparam int FC_ALARM1    = 1;
   localparam int FC_MINUTE    = 0;

   // Mask A holds the two fixture bits swapped against flags A.
   localparam int MA_FIX_FALL  = 5;
   localparam int MA_FIX_RISE  = 4;

   // Manual reset time select field.
   localparam int MR_SEL_MSB   = 2;
   localparam int MR_SEL_LSB   = 0;

   // Debounce channels.
   localparam int CH_KEY       = 0;
   localparam int CH_FIX       = 1;
   localparam int CH_ADAPTER   = 2;
   localparam int CHANNELS     = 3;

   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Serial link states, one-hot.
   typedef enum logic [8:0] {
      S_IDLE      = 9'h001,
      S_ADDR      = 9'h002,
      S_ADDR_ACK  = 9'h004,
      S_REG       = 9'h008,
      S_REG_ACK   = 9'h010,
      S_WRITE     = 9'h020,
      S_WRITE_ACK = 9'h040,
      S_READ      = 9'h080,
      S_READ_ACK  = 9'h100
   } link_state_t;

   // Seconds selected by the manual reset time code.
   function automatic count_t mr_seconds(input logic [2:0] code);
      case (code)
         3'h0:    mr_seconds = 32'h0000_0009;
         3'h1:    mr_seconds = 32'h0000_000A;
         3'h2:    mr_seconds = 32'h0000_0003;
         3'h3:    mr_seconds = 32'h0000_0004;
         3'h4:    mr_seconds = 32'h0000_0005;
         3'h5:    mr_seconds = 32'h0000_0006;
         3'h6:    mr_seconds = 32'h0000_0007;
         default: mr_seconds = 32'h0000_0008;
      endcase
   endfunction

endpackage

/* core/event_filter.sv */
// Debounce filter with edge pulses for the slow input pins.
`timescale 1ns/1ns
module event_filter (
   input  wire logic                            clk,
   input  wire logic                            reset,
   input  wire logic [pmic_irq_pkg::CHANNELS-1:0] raw_level,
   output logic      [pmic_irq_pkg::CHANNELS-1:0] stable_level,
   output logic      [pmic_irq_pkg::CHANNELS-1:0] rise_pulse,
   output logic      [pmic_irq_pkg::CHANNELS-1:0] fall_pulse
);
   import pmic_irq_pkg::*;

   typedef struct packed {
      logic [CHANNELS-1:0]                   level;
      logic [CHANNELS-1:0]                   rise;
      logic [CHANNELS-1:0]                   fall;
      logic [CHANNELS-1:0][$bits(filt_count_t)-1:0] count;
   } filt_state_t;

   filt_state_t r;
   filt_state_t next_r;
   logic [CHANNELS-1:0]                       ch_level;
   logic [CHANNELS-1:0]                       ch_rise;
   logic [CHANNELS-1:0]                       ch_fall;
   logic [CHANNELS-1:0][$bits(filt_count_t)-1:0] ch_count;

   // A new level is taken only after it held for the full debounce time.
   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      always_comb begin
         ch_level[i] = r.level[i];
         ch_rise[i]  = 1'b0;
         ch_fall[i]  = 1'b0;
         ch_count[i] = '0;
         if (raw_level[i] != r.level[i]) begin
            if (r.count[i] == DEBOUNCE_LAST) begin
               ch_level[i] = raw_level[i];
               ch_rise[i]  = raw_level[i];
               ch_fall[i]  = ~raw_level[i];
            end else begin
               ch_count[i] = r.count[i] + 12'h001;
            end
         end
      end
   end

   // Collect the channel results into the next state.
   always_comb begin
      next_r       = r;
      next_r.level = ch_level;
      next_r.rise  = ch_rise;
      next_r.fall  = ch_fall;
      next_r.count = ch_count;
   end

   // State register.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign stable_level = r.level;
   assign rise_pulse   = r.rise;
   assign fall_pulse   = r.fall;
endmodule

/* core/hold_timer.sv */
// Counts how long a condition holds and pulses once at the limit.
`timescale 1ns/1ns
module hold_timer (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 hold,
   input  wire pmic_irq_pkg::count_t limit,
   output logic                      fire
);
   import pmic_irq_pkg::*;

   typedef struct packed {
      count_t count;
      logic   done;
      logic   fire;
   } hold_state_t;

   hold_state_t r;
   hold_state_t next_r;

   // Fires once per hold; dropping the condition rearms the timer.
   always_comb begin
      next_r      = r;
      next_r.fire = 1'b0;
      if (!hold) begin
         next_r.count = '0;
         next_r.done  = 1'b0;
      end else if (!r.done) begin
         if (r.count == limit) begin
            next_r.fire = 1'b1;
            next_r.done = 1'b1;
         end else begin
            next_r.count = r.count + 32'h0000_0001;
         end
      end
   end

   // State register.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign fire = r.fire;
endmodule

/* core/pmic_event_irq_status_regs.sv */
// Event flags, masks, status and serial register port of the power chip.
`timescale 1ns/1ns
module pmic_event_irq_status_regs #(
   parameter pmic_irq_pkg::count_t TICKS_PER_SECOND =
      pmic_irq_pkg::TICKS_PER_SECOND,
   parameter logic [6:0]           DEVICE_ADDRESS   = 7'h66,
   // Revision code; the value is arbitrary.
   parameter logic [3:0]           REVISION_CODE    = 4'hA
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       power_key_input,
   input  wire logic       factory_fixture_input_n,
   input  wire logic       adapter_ok_input_n,
   input  wire logic       manual_reset_input_one_n,
   input  wire logic       manual_reset_input_two_n,
   input  wire logic       warm_reset_event,
   input  wire logic       sudden_power_loss_event,
   input  wire logic       alarm_one_event,
   input  wire logic       alarm_two_event,
   input  wire logic       second_tick_event,
   input  wire logic       minute_tick_event,
   input  wire logic       warm_reset_occurred,
   input  wire logic       power_loss_occurred,
   input  wire logic       alarm_one_reached,
   input  wire logic       alarm_two_reached,
   input  wire logic       battery_monitor_one_level,
   input  wire logic       battery_monitor_two_level,
   input  wire logic [6:0] power_on_cause_bits,
   output logic            interrupt_request
);
   import pmic_irq_pkg::*;

   typedef struct packed {
      link_state_t state;
      logic [3:0]  bits;
      byte_t       shift;
      byte_t       ptr;
      logic        rw;
      logic        acked;
      logic        drive_low;
      logic        scl_q;
      logic        sda_q;
      byte_t       flags_a;
      byte_t       flags_b;
      byte_t       flags_clk;
      byte_t       mask_a;
      byte_t       mask_b;
      byte_t       mask_clk;
      byte_t       mr_ctrl;
      logic [6:0]  cause;
      logic        cause_taken;
      logic        irq;
   } regs_t;

   localparam regs_t REGS_RESET = '{
      state:       S_IDLE,
      bits:        4'h0,
      shift:       ZERO_BYTE,
      ptr:         ZERO_BYTE,
      rw:          1'b0,
      acked:       1'b0,
      drive_low:   1'b0,
      scl_q:       1'b1,
      sda_q:       1'b1,
      flags_a:     ZERO_BYTE,
      flags_b:     ZERO_BYTE,
      flags_clk:   ZERO_BYTE,
      mask_a:      MASK_A_RESET,
      mask_b:      MASK_B_RESET,
      mask_clk:    MASK_CLK_RESET,
      mr_ctrl:     MR_CTRL_RESET,
      cause:       7'h00,
      cause_taken: 1'b0,
      irq:         1'b0
   };

   regs_t               r;
   regs_t               next_r;
   logic [CHANNELS-1:0] pin_raw;
   logic [CHANNELS-1:0] pin_level;
   logic [CHANNELS-1:0] pin_rise;
   logic [CHANNELS-1:0] pin_fall;
   logic                long_press;
   logic                manual_hold;
   logic                manual_fire;
   count_t              long_limit;
   count_t              manual_limit;
   logic                scl_rise;
   logic                scl_fall;
   logic                start_seen;
   logic                stop_seen;
   logic                load;
   logic                wr;
   byte_t               rd_data;
   byte_t               ev_a;
   byte_t               ev_b;
   byte_t               ev_clk;
   byte_t               clr_a;
   byte_t               clr_b;
   byte_t               clr_clk;
   byte_t               mask_a_eff;

   // Debounce the key, fixture and adapter pins.
   assign pin_raw = {adapter_ok_input_n, factory_fixture_input_n,
                     power_key_input};

   event_filter u_filter (
      .clk          (clk),
      .reset        (reset),
      .raw_level    (pin_raw),
      .stable_level (pin_level),
      .rise_pulse   (pin_rise),
      .fall_pulse   (pin_fall)
   );

   // Long key press and manual reset hold timers.
   assign long_limit   = KEY_LONG_PRESS_S * TICKS_PER_SECOND;
   assign manual_limit = mr_seconds(r.mr_ctrl[MR_SEL_MSB:MR_SEL_LSB])
                         * TICKS_PER_SECOND;
   assign manual_hold  = ~manual_reset_input_one_n
                         & ~manual_reset_input_two_n;

   hold_timer u_key_timer (
      .clk   (clk),
      .reset (reset),
      .hold  (pin_level[CH_KEY]),
      .limit (long_limit),
      .fire  (long_press)
   );

   hold_timer u_manual_timer (
      .clk   (clk),
      .reset (reset),
      .hold  (manual_hold),
      .limit (manual_limit),
      .fire  (manual_fire)
   );

   // Bus conditions seen on the sampled serial lines.
   assign scl_rise   = scl & ~r.scl_q;
   assign scl_fall   = ~scl & r.scl_q;
   assign start_seen = scl & r.scl_q & r.sda_q & ~sda_in;
   assign stop_seen  = scl & r.scl_q & ~r.sda_q & sda_in;

   // Event vectors for the three flag registers.
   always_comb begin
      ev_a                 = ZERO_BYTE;
      ev_a[FA_FIX_RISE]    = pin_rise[CH_FIX];
      ev_a[FA_FIX_FALL]    = pin_fall[CH_FIX];
      ev_a[FA_KEY_LONG]    = long_press;
      ev_a[FA_KEY_FALL]    = pin_fall[CH_KEY];
      ev_a[FA_KEY_RISE]    = pin_rise[CH_KEY];
      ev_b                 = ZERO_BYTE;
      ev_b[FB_MANUAL]      = manual_fire;
      ev_b[FB_AD_FALL]     = pin_fall[CH_ADAPTER];
      ev_b[FB_AD_RISE]     = pin_rise[CH_ADAPTER];
      ev_clk               = ZERO_BYTE;
      ev_clk[FC_WARM]      = warm_reset_event;
      ev_clk[FC_SECOND]    = second_tick_event;
      ev_clk[FC_LOSS]      = sudden_power_loss_event;
      ev_clk[FC_ALARM2]    = alarm_two_event;
      ev_clk[FC_ALARM1]    = alarm_one_event;
      ev_clk[FC_MINUTE]    = minute_tick_event;
   end

   // Mask A realigned to flag A positions; fixture bits are swapped.
   always_comb begin
      mask_a_eff              = r.mask_a;
      mask_a_eff[FA_FIX_RISE] = r.mask_a[MA_FIX_RISE];
      mask_a_eff[FA_FIX_FALL] = r.mask_a[MA_FIX_FALL];
   end

   // Read data for the register at the current pointer.
   always_comb begin
      case (r.ptr)
         ADDR_REVISION:  rd_data = {4'h0, REVISION_CODE};
         ADDR_FLAGS_A:   rd_data = r.flags_a;
         ADDR_FLAGS_B:   rd_data = r.flags_b;
         ADDR_FLAGS_CLK: rd_data = r.flags_clk;
         ADDR_MASK_A:    rd_data = r.mask_a;
         ADDR_MASK_B:    rd_data = r.mask_b;
         ADDR_MASK_CLK:  rd_data = r.mask_clk;
         ADDR_STATUS_A:  rd_data = {warm_reset_occurred,
                                    power_loss_occurred,
                                    alarm_two_reached,
                                    alarm_one_reached,
                                    battery_monitor_two_level,
                                    battery_monitor_one_level,
                                    pin_level[CH_FIX],
                                    pin_level[CH_KEY]};
         ADDR_MR_CTRL:   rd_data = r.mr_ctrl;
         ADDR_CAUSE:     rd_data = {1'b0, r.cause};
         default:        rd_data = ZERO_BYTE;
      endcase
   end

   // Serial slave, flag, mask and cause update.
   always_comb begin
      next_r       = r;
      load         = 1'b0;
      wr           = 1'b0;
      next_r.scl_q = scl;
      next_r.sda_q = sda_in;
      if (start_seen) begin
         next_r.state     = S_ADDR;
         next_r.bits      = 4'h0;
         next_r.drive_low = 1'b0;
      end else if (stop_seen) begin
         next_r.state     = S_IDLE;
         next_r.drive_low = 1'b0;
      end else if (scl_rise) begin
         case (r.state)
            S_ADDR, S_REG, S_WRITE: begin
               next_r.shift = {r.shift[6:0], sda_in};
               next_r.bits  = r.bits + 4'h1;
            end
            S_READ_ACK: next_r.acked = ~sda_in;
            default:    next_r.acked = r.acked;
         endcase
      end else if (scl_fall) begin
         case (r.state)
            S_ADDR: begin
               if (r.bits == BYTE_BITS) begin
                  if (r.shift[7:1] == DEVICE_ADDRESS) begin
                     next_r.state     = S_ADDR_ACK;
                     next_r.drive_low = 1'b1;
                     next_r.rw        = r.shift[0];
                  end else begin
                     next_r.state = S_IDLE;
                  end
               end
            end
            S_ADDR_ACK, S_READ_ACK: begin
               next_r.drive_low = 1'b0;
               next_r.bits      = 4'h0;
               if (r.state == S_ADDR_ACK && !r.rw) begin
                  next_r.state = S_REG;
               end else if (r.state == S_ADDR_ACK || r.acked) begin
                  load             = 1'b1;
                  next_r.shift     = rd_data;
                  next_r.drive_low = ~rd_data[7];
                  next_r.bits      = 4'h1;
                  next_r.ptr       = r.ptr + 8'h01;
                  next_r.state     = S_READ;
               end else begin
                  next_r.state = S_IDLE;
               end
            end
            S_REG: begin
               if (r.bits == BYTE_BITS) begin
                  next_r.ptr       = r.shift;
                  next_r.state     = S_REG_ACK;
                  next_r.drive_low = 1'b1;
               end
            end
            S_WRITE: begin
               if (r.bits == BYTE_BITS) begin
                  wr               = 1'b1;
                  next_r.ptr       = r.ptr + 8'h01;
                  next_r.state     = S_WRITE_ACK;
                  next_r.drive_low = 1'b1;
               end
            end
            S_REG_ACK, S_WRITE_ACK: begin
               next_r.drive_low = 1'b0;
               next_r.bits      = 4'h0;
               next_r.state     = S_WRITE;
            end
            S_READ: begin
               if (r.bits == BYTE_BITS) begin
                  next_r.drive_low = 1'b0;
                  next_r.state     = S_READ_ACK;
               end else begin
                  next_r.shift     = {r.shift[6:0], 1'b0};
                  next_r.drive_low = ~r.shift[6];
                  next_r.bits      = r.bits + 4'h1;
               end
            end
            default: next_r.state = S_IDLE;
         endcase
      end

      // Host writes to the mask and control registers.
      if (wr) begin
         case (r.ptr)
            ADDR_MASK_A:   next_r.mask_a   = r.shift;
            ADDR_MASK_B:   next_r.mask_b   = r.shift;
            ADDR_MASK_CLK: next_r.mask_clk = r.shift;
            ADDR_MR_CTRL:  next_r.mr_ctrl  = r.shift;
            default:       next_r.mr_ctrl  = r.mr_ctrl;
         endcase
      end

      // Read clears only the bits returned; new events win over the clear.
      clr_a   = (load && r.ptr == ADDR_FLAGS_A)   ? rd_data : ZERO_BYTE;
      clr_b   = (load && r.ptr == ADDR_FLAGS_B)   ? rd_data : ZERO_BYTE;
      clr_clk = (load && r.ptr == ADDR_FLAGS_CLK) ? rd_data : ZERO_BYTE;
      next_r.flags_a   = (r.flags_a & ~clr_a) | ev_a;
      next_r.flags_b   = (r.flags_b & ~clr_b) | ev_b;
      next_r.flags_clk = (r.flags_clk & ~clr_clk) | ev_clk;

      // Interrupt while any unmasked flag is set.
      next_r.irq = |(r.flags_a & ~mask_a_eff)
                 | |(r.flags_b & ~r.mask_b)
                 | |(r.flags_clk & ~r.mask_clk);

      // Power-on cause is captured once after reset release.
      if (!r.cause_taken) begin
         next_r.cause       = power_on_cause_bits;
         next_r.cause_taken = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= REGS_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Open-drain data line: only ever pulls low.
   assign sda_out           = 1'b0;
   assign sda_oe            = r.drive_low;
   assign interrupt_request = r.irq;
endmodule

/* tb/pmic_irq_sva.sv */
// Assertions on the ports of the event and interrupt register block.
`timescale 1ns/1ns
module pmic_irq_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic warm_reset_event,
   input wire logic interrupt_request
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // A long high serial clock with the request up, and a recent clock fall.
   sequence quiet_high;
      (scl && interrupt_request)[*8];
   endsequence
   sequence recent_fall;
      !scl && ($past(scl, 2) || $past(scl, 3) || $past(scl, 4));
   endsequence
   quiet_out_a: assert property (disable iff (1'b0)
      reset |-> !interrupt_request && !sda_oe) else $error("active in reset");
   pin_low_a: assert property (sda_out == 1'b0)
      else $error("open drain value not low");
   irq_hold_a: assert property (quiet_high |=> interrupt_request)
      else $error("request dropped with no access");
   oe_on_low_a: assert property ($changed(sda_oe) |-> !scl)
      else $error("data drive changed while clock high");
   oe_stands_a: assert property ($rose(scl) |=> $stable(sda_oe)[*3])
      else $error("data drive moved during high");
   ack_delay_a: assert property ($rose(sda_oe) |-> recent_fall)
      else $error("data drive started off time");
   oe_release_a: assert property ($rose(sda_oe) |-> ##[1:200] !sda_oe)
      else $error("data line held too long");
   irq_delay_a: assert property ($rose(warm_reset_event) &&
      !interrupt_request |=> !interrupt_request) else $error("request early");
endmodule

bind pmic_event_irq_status_regs pmic_irq_sva u_sva (
   .clk(clk), .reset(reset), .scl(scl), .sda_out(sda_out),
   .sda_oe(sda_oe), .warm_reset_event(warm_reset_event),
   .interrupt_request(interrupt_request)
);

/* tb/serial_host.sv */
// Serial bus master model standing in for the host processor.
`timescale 1ns/1ns
module serial_host #(
   parameter logic [6:0] DEV = 7'h66
) (
   input  wire logic clk,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda_in
);
   import pmic_irq_pkg::*;
   logic  sd = 1'b1;
   logic  nak = 1'b0;
   byte_t got [12];
   // A released data line is pulled up; either side may pull it low.
   assign sda_in = sd & ~sda_oe;
   initial scl = 1'b1;
   // Drives clock and data after an edge and holds them n edges.
   task automatic tick(input logic c, input logic d, input int n);
      @(posedge clk);
      scl <= c;
      sd <= d;
      repeat (n - 1) @(posedge clk);
   endtask
   // Start (a high) or stop (a low): data is set while clock is low, then flips while clock is high.
   task automatic cond(input logic a);
      tick(1'b0, sd, 4);
      tick(1'b0, a, 4);
      tick(1'b1, a, 8);
      tick(1'b1, ~a, 8);
   endtask
   // Eight bits and the acknowledge bit, MSB first, each sampled high.
   task automatic xfer(input logic [8:0] v, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         tick(1'b0, sd, 4);
         tick(1'b0, v[i], 4);
         tick(1'b1, sd, 8);
         q[i] = sda_in;
      end
   endtask
   task automatic send(input logic [8:0] v);
      logic [8:0] q;
      xfer(v, q);
      nak |= q[0];
   endtask
   // Writes one register.
   task automatic wr(input byte_t a, input byte_t d);
      cond(1'b1);
      send({DEV, 2'b01});
      send({a, 1'b1});
      send({d, 1'b1});
      cond(1'b0);
   endtask
   // Reads n registers in one sequence, starting at register a.
   task automatic rd(input byte_t a, input int n);
      logic [8:0] q;
      cond(1'b1);
      send({DEV, 2'b01});
      send({a, 1'b1});
      cond(1'b1);
      send({DEV, 2'b11});
      for (int i = 0; i < n; i++) begin
         xfer({8'hFF, i == n - 1}, q);
         got[i] = q[8:1];
      end
      cond(1'b0);
   endtask
endmodule

/* tb/pmic_event_irq_status_regs_bench.sv */
// Self-checking bench for the event, mask and status register block.
`timescale 1ns/1ns
module pmic_event_irq_status_regs_bench;
   import pmic_irq_pkg::*;
   localparam int TPS = 20;
   logic       clk = 1'b0;
   logic       reset, scl, sda_in, sda_oe, irq;
   logic       key, fix_n, ad_n, mr1, mr2;
   logic [5:0] ev, st;
   logic [6:0] cause;
   int         err_count = 0;
   int         check_count = 0;
   int         cyc = 0;
   // Revision code 4'h5 is arbitrary.
   pmic_event_irq_status_regs #(.TICKS_PER_SECOND(TPS), .REVISION_CODE(4'h5))
   u_dut (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_in),
      .sda_out(), .sda_oe(sda_oe), .power_key_input(key),
      .factory_fixture_input_n(fix_n), .adapter_ok_input_n(ad_n),
      .manual_reset_input_one_n(mr1), .manual_reset_input_two_n(mr2),
      .warm_reset_event(ev[5]), .sudden_power_loss_event(ev[3]),
      .alarm_one_event(ev[1]), .alarm_two_event(ev[2]),
      .second_tick_event(ev[4]), .minute_tick_event(ev[0]),
      .warm_reset_occurred(st[5]), .power_loss_occurred(st[4]),
      .alarm_one_reached(st[2]), .alarm_two_reached(st[3]),
      .battery_monitor_one_level(st[0]), .battery_monitor_two_level(st[1]),
      .power_on_cause_bits(cause), .interrupt_request(irq));
   serial_host host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
   // Clock and run-time ceiling.
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         final_report();
      end
   end
   task automatic check(input string n, input byte_t seen, input byte_t exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [5:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 6'h00;
      wait_cyc(3);
   endtask
   // Reset values, revision, status, unmapped reads and power-on cause.
   task automatic t_reset();
      byte_t e [12] = '{8'h05, 0, 0, 0, 0, 8'h78, 0, 8'hA8, 0, 0, 0, 8'h0E};
      host.rd(8'h00, 12);
      for (int i = 0; i < 12; i++) check("reg", host.got[i], e[i]);
      host.rd(8'hE0, 1);
      check("cause", host.got[0], 8'h55);
   endtask
   // Each clock event alone, then all masked and released.
   task automatic t_clock();
      for (int i = 0; i < 6; i++) begin
         pulse(6'h01 << i);
         check("irq", {7'h00, irq}, 8'h01);
         host.rd(8'h01, 3);
         check("clk flags", host.got[2], 8'h01 << i);
         wait_cyc(3);
         check("irq clr", {7'h00, irq}, 8'h00);
      end
      host.wr(8'h06, 8'h3F);
      pulse(6'h3F);
      check("irq masked", {7'h00, irq}, 8'h00);
      host.wr(8'h06, 8'h00);
      wait_cyc(3);
      check("irq unmask", {7'h00, irq}, 8'h01);
      host.rd(8'h01, 3);
      check("clk all", host.got[2], 8'h3F);
   endtask
   // Pin change, settle past the filter, then request, flags and status.
   task automatic step(input logic [2:0] p, input logic [5:0] s,
                       input byte_t ea, eb, es, input logic ei);
      @(posedge clk);
      {key, fix_n, ad_n} <= p;
      st <= s;
      wait_cyc(4100);
      check("irq pin", {7'h00, irq}, {7'h00, ei});
      host.rd(8'h01, 3);
      check("flags a", host.got[0], ea);
      check("flags b", host.got[1], eb);
      host.rd(8'h07, 1);
      check("status", host.got[0], es);
   endtask
   task automatic t_pins();
      step(3'b100, 6'h2A, 8'h09, 8'h00, 8'hA9, 1'b1);
      step(3'b011, 6'h15, 8'h22, 8'h01, 8'h56, 1'b1);
      host.wr(8'h04, 8'h20);
      host.wr(8'h05, 8'h7A);
      host.rd(8'h04, 2);
      check("mask a", host.got[0], 8'h20);
      check("mask b", host.got[1], 8'h7A);
      step(3'b000, 6'h2A, 8'h10, 8'h02, 8'hA8, 1'b0);
   endtask
   // Three second hold time: one pin alone does nothing, both pins fire.
   task automatic t_manual();
      host.wr(8'h0B, 8'h0A);
      @(posedge clk);
      mr1 <= 1'b0;
      wait_cyc(100);
      check("mr one", {7'h00, irq}, 8'h00);
      @(posedge clk);
      mr2 <= 1'b0;
      wait_cyc(3 * TPS - 5);
      check("mr early", {7'h00, irq}, 8'h00);
      wait_cyc(12);
      check("mr fire", {7'h00, irq}, 8'h01);
      host.rd(8'h01, 3);
      check("mr flag", host.got[1], 8'h04);
      check("acks", {7'h00, host.nak}, 8'h00);
   endtask
   task automatic final_report();
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence.
   initial begin
      reset = 1'b1;
      {key, fix_n, ad_n, mr1, mr2} = 5'h03;
      ev = 6'h00;
      st = 6'h2A;
      cause = 7'h55;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      // The cause is taken at the first edge out of reset, then frozen.
      @(posedge clk);
      cause <= 7'h2A;
      wait_cyc(1);
      t_reset();
      t_clock();
      t_pins();
      t_manual();
      final_report();
   end
endmodule
